/* File: zvs_consts.vh */
`ifndef ZVS_CONSTS_VH
`define ZVS_CONSTS_VH
// ****************************************
// Oscillator defaults, in ref_clk cycles
// ****************************************
`define CHARGE_CYCLES_DEFAULT 16'd40
`define DISCHARGE_CYCLES_DEFAULT 16'd4
// Resonant delay control full scale: 2.00 V maps to this code
`define RESONANT_DELAY_CTRL_FULL_SCALE 8'hff
// Fastest switching: 2 MHz oscillator at 40 MHz clock
`define REF_CLK_KHZ 40000
`define MAX_OSC_KHZ 2000
`define MIN_PERIOD_CYCLES (`REF_CLK_KHZ / `MAX_OSC_KHZ)
`endif

/* File: osc_timebase.v */
`timescale 1ns/1ps
`include "zvs_consts.vh"
// ****************************************
// Charge/discharge oscillator timebase
// ****************************************
module osc_timebase #(
	parameter W = 16
) (
	ref_clk,
	srst,
	charge_cycles,
	discharge_cycles,
	charging,
	period_start,
	discharge_start,
	phase_count
);
	input wire ref_clk;
	input wire srst;
	input wire [W-1:0] charge_cycles;
	input wire [W-1:0] discharge_cycles;
	output reg charging;
	output wire period_start;
	output wire discharge_start;
	output reg [W-1:0] phase_count;

	// Floor on the charge phase, one cycle left for discharge
	localparam [31:0] min_charge_word = `MIN_PERIOD_CYCLES - 1;

	wire [W-1:0] min_charge;
	wire [W-1:0] charge_len;
	wire [W-1:0] dis_len;
	wire phase_end;

	assign min_charge = min_charge_word[W-1:0];
	// Clamp so the period never undercuts the fastest allowed rate
	assign charge_len = (charge_cycles < min_charge) ? min_charge : charge_cycles;
	assign dis_len = (discharge_cycles == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : discharge_cycles;
	assign phase_end = charging ? (phase_count >= charge_len - 1'b1) : (phase_count >= dis_len - 1'b1);
	assign period_start = phase_end & ~charging;
	assign discharge_start = phase_end & charging;

	always @(posedge ref_clk) begin
		if (srst) begin
			charging <= 1'b1;
			phase_count <= {W{1'b0}};
		end else if (phase_end) begin
			charging <= ~charging;
			phase_count <= {W{1'b0}};
		end else begin
			phase_count <= phase_count + 1'b1;
		end
	end
endmodule

/* File: zvs_full_bridge_pwm_sequencer.v */
`timescale 1ns/1ps
`include "zvs_consts.vh"
// Function
// - Upper outputs alternate at fixed half duty
// - Lower outputs modulated, alternating, one per half
// - Resonant delay is control fraction of deadtime
// - Deadtime equals oscillator discharge phase
// - Period is charge phase then discharge phase
// - Full switching cycle spans two oscillator periods
// - Oscillator rate programmable up to 2 MHz
// - Compare sense input against overcurrent threshold
// - Overcurrent ends pulse, no latched shutdown
// - Clamp sense input after each lower pulse
// - Discharge ramp input after each pulse
// - Ramp above error ends lower pulse
// - Soft-start level widens allowed pulse
// - Error limited to soft-start until exceeded
// - Inhibit input forces outputs low and restarts soft-start
// - Undervoltage lockout holds outputs off
module zvs_full_bridge_pwm_sequencer #(
	parameter W = 16,
	parameter DW = 8
) (
	ref_clk,
	srst,
	charge_cycles,
	deadtime_cycles,
	resonant_delay_ctrl,
	error_voltage_in,
	soft_start_level,
	ramp_level,
	overcurrent_cmp,
	inhibit_cmp,
	undervoltage_lockout,
	upper_left_drive,
	upper_right_drive,
	lower_left_drive,
	lower_right_drive,
	sense_clamp,
	ramp_discharge,
	soft_start_active
);
	input wire ref_clk;
	input wire srst;
	input wire [W-1:0] charge_cycles;
	input wire [W-1:0] deadtime_cycles;
	input wire [DW-1:0] resonant_delay_ctrl;
	input wire [W-1:0] error_voltage_in;
	input wire [W-1:0] soft_start_level;
	input wire [W-1:0] ramp_level;
	input wire overcurrent_cmp;
	input wire inhibit_cmp;
	input wire undervoltage_lockout;
	output reg upper_left_drive;
	output reg upper_right_drive;
	output reg lower_left_drive;
	output reg lower_right_drive;
	output reg sense_clamp;
	output reg ramp_discharge;
	output reg soft_start_active;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg oc_meta_reg, oc_reg, inh_meta_reg, inh_reg, uv_meta_reg, uv_reg;
	always @(posedge ref_clk) begin
		if (srst) begin
			oc_meta_reg <= 1'b0;
			oc_reg <= 1'b0;
			inh_meta_reg <= 1'b1;
			inh_reg <= 1'b1;
			uv_meta_reg <= 1'b1;
			uv_reg <= 1'b1;
		end else begin
			oc_meta_reg <= overcurrent_cmp;
			oc_reg <= oc_meta_reg;
			inh_meta_reg <= inhibit_cmp;
			inh_reg <= inh_meta_reg;
			uv_meta_reg <= undervoltage_lockout;
			uv_reg <= uv_meta_reg;
		end
	end

	// ****************************************
	// Oscillator
	// ****************************************
	wire charging, period_start, discharge_start;
	wire [W-1:0] phase_count;
	osc_timebase #(.W(W)) u_osc (
		.ref_clk(ref_clk),
		.srst(srst),
		.charge_cycles(charge_cycles),
		.discharge_cycles(deadtime_cycles),
		.charging(charging),
		.period_start(period_start),
		.discharge_start(discharge_start),
		.phase_count(phase_count)
	);

	// ****************************************
	// Sampled analog values, once per period; ramp sampled every cycle
	// ****************************************
	reg [W-1:0] err_reg, ss_reg, ramp_reg, dead_reg;
	reg [DW-1:0] resonant_delay_ctrl_reg;
	always @(posedge ref_clk) begin
		if (srst) begin
			err_reg <= {W{1'b0}};
			ss_reg <= {W{1'b0}};
			dead_reg <= {W{1'b0}};
			resonant_delay_ctrl_reg <= {DW{1'b0}};
		end else if (period_start) begin
			err_reg <= error_voltage_in;
			ss_reg <= soft_start_level;
			dead_reg <= deadtime_cycles;
			resonant_delay_ctrl_reg <= resonant_delay_ctrl;
		end
	end
	always @(posedge ref_clk) begin
		if (srst) begin
			ramp_reg <= {W{1'b0}};
		end else begin
			ramp_reg <= ramp_level;
		end
	end

	// Soft-start caps the effective error level
	wire [W-1:0] eff_err;
	assign eff_err = (ss_reg < err_reg) ? ss_reg : err_reg;

	always @(posedge ref_clk) begin
		if (srst) begin
			soft_start_active <= 1'b1;
		end else if (inh_reg | uv_reg) begin
			soft_start_active <= 1'b1;
		end else if (period_start & (ss_reg > err_reg)) begin
			soft_start_active <= 1'b0;
		end
	end

	// Resonant delay = deadtime * ctrl / 256, truncated
	wire [W+DW-1:0] delay_prod;
	wire [W-1:0] res_delay;
	assign delay_prod = dead_reg * resonant_delay_ctrl_reg;
	assign res_delay = delay_prod[W+DW-1:DW];

	// ****************************************
	// Bridge sequencing
	// ****************************************
	wire outputs_off;
	assign outputs_off = inh_reg | uv_reg;

	reg side_reg;      // 0: left upper active
	reg pulse_armed_reg;
	reg pulse_on_reg;
	reg [W-1:0] delay_cnt_reg;
	reg delay_wait_reg;

	always @(posedge ref_clk) begin
		if (srst) begin
			side_reg <= 1'b0;
		end else if (period_start) begin
			side_reg <= ~side_reg;
		end
	end

	wire pulse_end;
	assign pulse_end = pulse_on_reg & (oc_reg | (ramp_reg > eff_err) | discharge_start);

	always @(posedge ref_clk) begin
		if (srst) begin
			pulse_on_reg <= 1'b0;
			delay_wait_reg <= 1'b0;
			delay_cnt_reg <= {W{1'b0}};
			pulse_armed_reg <= 1'b0;
		end else if (outputs_off) begin
			pulse_on_reg <= 1'b0;
			delay_wait_reg <= 1'b0;
			pulse_armed_reg <= 1'b0;
		end else if (period_start) begin
			pulse_on_reg <= 1'b0;
			pulse_armed_reg <= 1'b1;
			delay_wait_reg <= (res_delay != {W{1'b0}});
			delay_cnt_reg <= res_delay;
		end else if (delay_wait_reg) begin
			if (delay_cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
				delay_wait_reg <= 1'b0;
			end
			delay_cnt_reg <= delay_cnt_reg - 1'b1;
		end else if (pulse_armed_reg & charging) begin
			// One lower pulse per half-cycle
			pulse_on_reg <= 1'b1;
			pulse_armed_reg <= 1'b0;
		end else if (pulse_end) begin
			pulse_on_reg <= 1'b0;
		end
	end

	// ****************************************
	// Registered drive outputs
	// ****************************************
	always @(posedge ref_clk) begin
		if (srst | outputs_off) begin
			upper_left_drive <= 1'b0;
			upper_right_drive <= 1'b0;
			lower_left_drive <= 1'b0;
			lower_right_drive <= 1'b0;
		end else begin
			upper_left_drive <= ~side_reg;
			upper_right_drive <= side_reg;
			// Diagonal pair: lower on side opposite upper
			lower_right_drive <= pulse_on_reg & ~pulse_end & ~side_reg;
			lower_left_drive <= pulse_on_reg & ~pulse_end & side_reg;
		end
	end

	// Clamp sense and ramp whenever no pulse is live
	// Forced-off counts too: a pulse cut by inhibit must still discharge
	always @(posedge ref_clk) begin
		if (srst) begin
			sense_clamp <= 1'b1;
			ramp_discharge <= 1'b1;
		end else begin
			sense_clamp <= ~pulse_on_reg | pulse_end | outputs_off;
			ramp_discharge <= ~pulse_on_reg | pulse_end | outputs_off;
		end
	end
endmodule

/* File: zvs_chk.sv */
`timescale 1ns/1ps
module zvs_chk (
	input wire ref_clk,
	input wire srst,
	input wire overcurrent_cmp,
	input wire inhibit_cmp,
	input wire undervoltage_lockout,
	input wire upper_left_drive,
	input wire upper_right_drive,
	input wire lower_left_drive,
	input wire lower_right_drive,
	input wire sense_clamp,
	input wire ramp_discharge
);
	wire lo = lower_left_drive | lower_right_drive;
	wire drv = lo | upper_left_drive | upper_right_drive;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_upper_excl: assert property (!(upper_left_drive && upper_right_drive)) else $error("upper overlap");
	chk_lower_excl: assert property (!(lower_left_drive && lower_right_drive)) else $error("lower overlap");
	chk_diag_pair: assert property (lower_left_drive |-> upper_right_drive) else $error("not diagonal");
	chk_diag_right: assert property (lower_right_drive |-> upper_left_drive) else $error("right not diagonal");
	chk_sense_clamp: assert property (sense_clamp != lo) else $error("clamp wrong");
	chk_ramp_clear: assert property ($fell(lo) |-> ramp_discharge) else $error("ramp kept");
	chk_inhibit_off: assert property (inhibit_cmp [*4] |-> !drv) else $error("inhibit lost");
	chk_lockout_off: assert property (undervoltage_lockout [*4] |-> !drv) else $error("lockout lost");
	chk_oc_end: assert property (overcurrent_cmp [*3] |=> !lo) else $error("overcurrent lost");
endmodule
bind zvs_full_bridge_pwm_sequencer zvs_chk u_zvs_chk (.ref_clk, .srst, .overcurrent_cmp, .inhibit_cmp,
	.undervoltage_lockout, .upper_left_drive, .upper_right_drive, .lower_left_drive, .lower_right_drive,
	.sense_clamp, .ramp_discharge);

/* File: sense_net.sv */
`timescale 1ns/1ps
module sense_net (
	input wire ref_clk,
	input wire lower_on,
	input wire ramp_discharge,
	input wire [15:0] oc_limit,
	output reg [15:0] ramp_level,
	output wire overcurrent_cmp
);
	initial ramp_level = 16'h0000;
	// Current mode: one ramp feeds both compares
	always @(posedge ref_clk) begin
		if (ramp_discharge) begin
			ramp_level <= 16'h0000;
		end else if (lower_on) begin
			ramp_level <= ramp_level + 16'h0001;
		end
	end
	assign overcurrent_cmp = ramp_level > oc_limit;
endmodule

/* File: zvs_full_bridge_pwm_sequencer_test.sv */
`timescale 1ns/1ps
module zvs_full_bridge_pwm_sequencer_test;
	reg ref_clk = 1'b0;
	reg srst = 1'b1;
	reg inhibit_cmp = 1'b0;
	reg undervoltage_lockout = 1'b0;
	reg [7:0] resonant_delay_ctrl = 8'h00;
	reg [15:0] charge_cycles = 16'h001e;
	reg [15:0] deadtime_cycles = 16'h0006;
	reg [15:0] error_voltage_in = 16'h000a;
	reg [15:0] soft_start_level = 16'h0004;
	reg [15:0] oc_limit = 16'hffff;
	reg [15:0] nu, nl, nr, w, wm;
	wire [15:0] ramp_level;
	wire overcurrent_cmp, sense_clamp, ramp_discharge, soft_start_active;
	wire upper_left_drive, upper_right_drive, lower_left_drive, lower_right_drive;
	wire [3:0] drv = {upper_left_drive, upper_right_drive, lower_left_drive, lower_right_drive};
	integer fail_count = 0;
	integer total_checks = 0;
	integer n, m, k;
	always #12.5 ref_clk = ~ref_clk;
	zvs_full_bridge_pwm_sequencer u_zvs_full_bridge_pwm_sequencer (.ref_clk, .srst, .charge_cycles, .deadtime_cycles,
		.resonant_delay_ctrl, .error_voltage_in, .soft_start_level, .ramp_level, .overcurrent_cmp, .inhibit_cmp,
		.undervoltage_lockout, .upper_left_drive, .upper_right_drive, .lower_left_drive, .lower_right_drive,
		.sense_clamp, .ramp_discharge, .soft_start_active);
	sense_net u_sense_net (.ref_clk, .lower_on(drv[1] | drv[0]), .ramp_discharge, .oc_limit, .ramp_level,
		.overcurrent_cmp);
	task check(input [15:0] seen, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("BAD %0t %h %h", $time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d fails %0d", total_checks, fail_count);
			if (fail_count == 0 && total_checks > 0) begin
				$display("TB: PASS");
			end else begin
				$display("TB: FAIL");
			end
			$finish;
		end
	endtask
	task wait_ul;
		begin
			for (n = 0; n < 300 && drv[3] !== 1'b0; n = n + 1) @(negedge ref_clk);
			for (n = n; n < 300 && drv[3] !== 1'b1; n = n + 1) @(negedge ref_clk);
			if (n > 299) begin
				fail_count = fail_count + 1;
				finish_test;
			end
		end
	endtask
	// Window of 720 cycles is exactly ten switching cycles
	task apply(input [15:0] ss, input [15:0] err, input [15:0] oc);
		reg [3:0] p;
		begin
			@(posedge ref_clk);
			soft_start_level <= ss;
			error_voltage_in <= err;
			oc_limit <= oc;
			wait_ul;
			{nu, nl, nr, w, wm} = 80'h0;
			p = drv;
			repeat (720) begin
				@(negedge ref_clk);
				nu = nu + drv[3] * !p[3];
				nl = nl + drv[1] * !p[1];
				nr = nr + drv[0] * !p[0];
				w = (drv[1] | drv[0]) ? w + 16'h0001 : 16'h0000;
				wm = (w > wm) ? w : wm;
				p = drv;
			end
		end
	endtask
	task t_pwm;
		begin
			apply(16'h0004, 16'h000a, 16'hffff);
			check(wm > 4 && wm < 10, 1);
			check(soft_start_active, 1);
			apply(16'hffff, 16'h000a, 16'hffff);
			check(wm > 10 && wm < 16, 1);
			check(soft_start_active, 0);
			check(nu, 16'h000a);
			check(nl, 16'h000a);
			check(nr, 16'h000a);
			$display("t_pwm done");
		end
	endtask
	task t_delay;
		begin
			for (k = 0; k < 3; k = k + 1) begin
				@(posedge ref_clk);
				resonant_delay_ctrl <= 8'h60 * k[1:0];
				wait_ul;
				wait_ul;
				for (m = 0; m < 40 && drv[1:0] == 2'b00; m = m + 1) @(negedge ref_clk);
				n = (deadtime_cycles * resonant_delay_ctrl) / 256;
				check(m == n || m == n + 1, 1);
			end
			$display("t_delay done");
		end
	endtask
	task t_oc;
		begin
			apply(16'hffff, 16'hffff, 16'hffff);
			check(wm > 20 && wm < 31, 1);
			apply(16'hffff, 16'hffff, 16'h0008);
			check(wm > 8 && wm < 16, 1);
			check(nl, 16'h000a);
			$display("t_oc done");
		end
	endtask
	task t_off(input sel);
		begin
			@(posedge ref_clk);
			inhibit_cmp <= !sel;
			undervoltage_lockout <= sel;
			repeat (54) @(negedge ref_clk);
			check({drv, sense_clamp, soft_start_active}, 16'h0003);
			@(posedge ref_clk);
			{inhibit_cmp, undervoltage_lockout} <= 2'b00;
			apply(16'hffff, 16'h000a, 16'hffff);
			check(nu, 16'h000a);
			$display("t_off done");
		end
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		#1;
		check({drv, sense_clamp, ramp_discharge, soft_start_active}, 16'h0007);
		@(posedge ref_clk);
		srst <= 1'b0;
		t_pwm;
		t_delay;
		t_oc;
		t_off(1'b0);
		t_off(1'b1);
		finish_test;
	end
endmodule
